// [src/bpci_pkg.sv]
// constants and carrier types for the pattern tester block
package bpci_pkg;
    // ============================================================
    // register offsets on the byte-wide parallel port
    localparam logic [7:0] BPCI_PAT_B0_OFF = 8'hDC;
    localparam logic [7:0] BPCI_PAT_B1_OFF = 8'hDD;
    localparam logic [7:0] BPCI_PAT_B2_OFF = 8'hDE;
    localparam logic [7:0] BPCI_PAT_B3_OFF = 8'hDF;
    localparam logic [7:0] BPCI_RXB_B0_OFF = 8'hE3;
    localparam logic [7:0] BPCI_RXB_B1_OFF = 8'hE4;
    localparam logic [7:0] BPCI_RXB_B2_OFF = 8'hE5;
    localparam logic [7:0] BPCI_RXB_B3_OFF = 8'hE6;
    localparam logic [7:0] BPCI_ERR_B0_OFF = 8'hE7;
    localparam logic [7:0] BPCI_ERR_B1_OFF = 8'hE8;
    localparam logic [7:0] BPCI_ERR_B2_OFF = 8'hE9;
    localparam logic [7:0] BPCI_CTRL_OFF = 8'hEA;
    // ============================================================
    // reset values and control fields
    localparam logic [7:0] BPCI_BYTE_RST = 8'h00;
    localparam logic [31:0] BPCI_PAT_RST = 32'h0000_0000;
    localparam logic [7:0] BPCI_CTRL_USED = 8'h5B;
    localparam int BPCI_EN_BIT = 0;
    localparam int BPCI_DIR_BIT = 1;
    localparam int BPCI_TRANSMIT_FRAMING_SELECT_BIT = 3;
    localparam int BPCI_TRANSMIT_BYTE_ALIGN_TOGGLE_BIT = 4;
    localparam int BPCI_RECEIVE_FRAMING_SELECT_BIT = 6;
    // ============================================================
    // counts
    localparam logic [5:0] BPCI_SYNC_LEN = 6'h20;
    localparam logic [3:0] BPCI_WORD_LAST = 4'hF;
    localparam logic [31:0] BPCI_BIT_MAX = 32'hFFFF_FFFF;
    localparam logic [23:0] BPCI_ERR_MAX = 24'hFF_FFFF;
    localparam int BPCI_FIFO_DEPTH = 8;
    localparam int BPCI_FIFO_WIDTH = 1;
    localparam int BPCI_PRBS_TAP_A = 14;
    localparam int BPCI_PRBS_TAP_B = 13;
    // ============================================================
    // modes and carriers
    typedef enum logic [1:0] {
        BPCI_MODE_REPEAT = 2'b00,
        BPCI_MODE_PRBS = 2'b01,
        BPCI_MODE_ALT = 2'b10,
        BPCI_MODE_DALY = 2'b11
    } bpci_mode_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bpci_bus_t;
    typedef struct packed {
        logic valid;
        logic data;
        logic fbit;
    } bpci_rx_t;
    typedef struct packed {
        logic req;
        logic fbit;
    } bpci_txreq_t;
    typedef struct packed {
        logic valid;
        logic data;
    } bpci_txout_t;
endpackage

// [src/bpci_top.sv]
// pattern tester: generator, checker, counters and register port
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// generic fifo
module bpci_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wptr_q;
    logic [AW:0] rptr_q;
    logic push;
    logic pop;
    assign in_ready_o = (wptr_q - rptr_q) != (AW+1)'(DEPTH);
    assign out_valid_o = wptr_q != rptr_q;
    assign out_data_o = mem_q[rptr_q[AW-1:0]];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_q[wptr_q[AW-1:0]] <= in_data_i;
        end
    end
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wptr_q <= '0;
            rptr_q <= '0;
        end
        else if (flush_i)
        begin
            wptr_q <= '0;
            rptr_q <= '0;
        end
        else
        begin
            wptr_q <= wptr_q + (AW+1)'(push);
            rptr_q <= rptr_q + (AW+1)'(pop);
        end
    end
endmodule // bpci_fifo

// Overview of operation
// (RULE_01) software loads pattern before generating or checking
// (RULE_02) four pattern bytes form one word, low first
// (RULE_03) pattern bit zero sent and expected first
// (RULE_04) software replicates short patterns across 32 bits
// (RULE_05) software writes all ones for pseudorandom
// (RULE_06) alternating words: bytes 0-1, then 2-3
// (RULE_07) bit counter counts each bit once synced
// (RULE_08) bit counter saturates, sets overflow flag
// (RULE_09) error counter counts mismatches once synced
// (RULE_10) error counter saturates, sets overflow flag
// (RULE_11) counter-clear toggle zeroes both counters
// (RULE_12) bit counter read as four bytes, LSB low
// (RULE_13) error counter read as three bytes, LSB low
// (RULE_14) control bit 0 enables tester
// (RULE_15) direction 0: line transmit, line receive
// (RULE_16) line direction allows framer loopback return
// (RULE_17) direction 1: backplane out, backplane in
// (RULE_18) software writes zero to control bits 2,5,7
// (RULE_19) transmit framing select fills framing bit
// (RULE_20) receive framing select passes framing bit
// (RULE_21) byte-align rising edge realigns generated pattern
// (RULE_22) alternating word repeats count times, then switches
// (RULE_23) sync after 32 consecutive matching bits
// (RULE_24) overflow flags latch, clear on read
// (RULE_25) disabled tester leaves counters unchanged
module bpci_top (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire bpci_pkg::bpci_bus_t host_bus_i,
    output logic [7:0] host_rdata_o,
    input wire bpci_pkg::bpci_mode_t pattern_mode_i,
    input wire logic [7:0] alternating_count_register_i,
    input wire logic counter_clear_control_i,
    input wire logic overflow_flags_read_i,
    input wire bpci_pkg::bpci_txreq_t line_tx_req_i,
    input wire bpci_pkg::bpci_txreq_t backplane_tx_req_i,
    output bpci_pkg::bpci_txout_t line_transmit_o,
    output bpci_pkg::bpci_txout_t backplane_receive_serial_out_o,
    input wire bpci_pkg::bpci_rx_t line_receive_i,
    input wire bpci_pkg::bpci_rx_t backplane_transmit_serial_in_i,
    output logic pattern_sync_flag_o,
    output logic bit_counter_overflow_flag_o,
    output logic error_counter_overflow_flag_o
);
    import bpci_pkg::*;

    // ============================================================
    // registers
    logic [31:0] pat_q;
    logic [7:0] ctrl_q;
    logic [7:0] rdata_q;
    logic en;
    logic dir;
    logic pat_wr;
    assign en = ctrl_q[BPCI_EN_BIT]; // RULE_14
    assign dir = ctrl_q[BPCI_DIR_BIT];
    assign pat_wr = host_bus_i.wr & (host_bus_i.addr >= BPCI_PAT_B0_OFF)
        & (host_bus_i.addr <= BPCI_PAT_B3_OFF);

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pat_q <= BPCI_PAT_RST;
            ctrl_q <= BPCI_BYTE_RST;
        end
        else if (host_bus_i.wr)
        begin
            if (host_bus_i.addr == BPCI_PAT_B0_OFF)
                pat_q[7:0] <= host_bus_i.wdata; // RULE_02
            else if (host_bus_i.addr == BPCI_PAT_B1_OFF)
                pat_q[15:8] <= host_bus_i.wdata;
            else if (host_bus_i.addr == BPCI_PAT_B2_OFF)
                pat_q[23:16] <= host_bus_i.wdata;
            else if (host_bus_i.addr == BPCI_PAT_B3_OFF)
                pat_q[31:24] <= host_bus_i.wdata;
            else if (host_bus_i.addr == BPCI_CTRL_OFF)
                ctrl_q <= host_bus_i.wdata & BPCI_CTRL_USED;
        end
    end

    // ============================================================
    // generator
    logic transmit_byte_align_toggle_prev_q;
    logic transmit_byte_align_toggle_rise;
    logic load;
    logic [31:0] gen_pat_q;
    logic [14:0] gen_lfsr_q;
    logic [3:0] gen_idx_q;
    logic gen_word_q;
    logic [7:0] gen_rep_q;
    logic gen_bit;
    logic prbs_bit;
    logic fifo_in_ready;
    logic fifo_ov;
    logic fifo_od;
    logic gen_step;
    assign transmit_byte_align_toggle_rise = ctrl_q[BPCI_TRANSMIT_BYTE_ALIGN_TOGGLE_BIT] & ~transmit_byte_align_toggle_prev_q; // RULE_21
    assign load = ~en | transmit_byte_align_toggle_rise | pat_wr;
    assign gen_step = en & fifo_in_ready;
    assign prbs_bit = gen_lfsr_q[BPCI_PRBS_TAP_A]
        ^ gen_lfsr_q[BPCI_PRBS_TAP_B];

    always_comb
    begin
        case (pattern_mode_i)
            BPCI_MODE_PRBS: gen_bit = prbs_bit;
            BPCI_MODE_ALT: gen_bit = gen_word_q ? pat_q[5'(gen_idx_q) + 5'h10]
                : pat_q[5'(gen_idx_q)]; // RULE_06
            default: gen_bit = gen_pat_q[0]; // RULE_03
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            transmit_byte_align_toggle_prev_q <= 1'b0;
        else
            transmit_byte_align_toggle_prev_q <= ctrl_q[BPCI_TRANSMIT_BYTE_ALIGN_TOGGLE_BIT];
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            gen_pat_q <= BPCI_PAT_RST;
            gen_lfsr_q <= '0;
            gen_idx_q <= '0;
            gen_word_q <= 1'b0;
            gen_rep_q <= '0;
        end
        else if (load)
        begin
            gen_pat_q <= pat_q; // RULE_21
            gen_lfsr_q <= pat_q[14:0];
            gen_idx_q <= '0;
            gen_word_q <= 1'b0;
            gen_rep_q <= '0;
        end
        else if (gen_step)
        begin
            gen_pat_q <= {gen_pat_q[0], gen_pat_q[31:1]};
            gen_lfsr_q <= {gen_lfsr_q[13:0], prbs_bit};
            gen_idx_q <= gen_idx_q + 4'h1;
            if (gen_idx_q == BPCI_WORD_LAST)
            begin
                if (gen_rep_q + 8'h01 >= alternating_count_register_i)
                begin
                    gen_word_q <= ~gen_word_q; // RULE_22
                    gen_rep_q <= '0;
                end
                else
                    gen_rep_q <= gen_rep_q + 8'h01;
            end
        end
    end

    // ============================================================
    // transmit path
    bpci_txreq_t tx_req;
    logic tx_drive;
    assign tx_req = dir ? backplane_tx_req_i : line_tx_req_i; // RULE_15
    assign tx_drive = en & tx_req.req
        & (ctrl_q[BPCI_TRANSMIT_FRAMING_SELECT_BIT] | ~tx_req.fbit); // RULE_19

    bpci_fifo #(
        .WIDTH(BPCI_FIFO_WIDTH),
        .DEPTH(BPCI_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .flush_i(load),
        .in_valid_i(en),
        .in_ready_o(fifo_in_ready),
        .in_data_i(gen_bit),
        .out_valid_o(fifo_ov),
        .out_ready_i(tx_drive),
        .out_data_o(fifo_od)
    );

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            line_transmit_o <= '0;
            backplane_receive_serial_out_o <= '0;
        end
        else
        begin
            line_transmit_o.valid <= tx_drive & fifo_ov & ~dir; // RULE_15
            line_transmit_o.data <= fifo_od & ~dir;
            backplane_receive_serial_out_o.valid <= tx_drive & fifo_ov
                & dir; // RULE_17
            backplane_receive_serial_out_o.data <= fifo_od & dir;
        end
    end

    // ============================================================
    // checker
    bpci_rx_t rx;
    logic take;
    logic [31:0] chk_pat_q;
    logic [14:0] hist_q;
    logic [5:0] match_q;
    logic sync_q;
    logic expect_bit;
    logic match;
    // line side also carries the framer loopback return
    assign rx = dir ? backplane_transmit_serial_in_i
        : line_receive_i; // RULE_16 RULE_17
    assign take = en & rx.valid
        & (ctrl_q[BPCI_RECEIVE_FRAMING_SELECT_BIT] | ~rx.fbit); // RULE_20
    assign expect_bit = (pattern_mode_i == BPCI_MODE_PRBS)
        ? (hist_q[BPCI_PRBS_TAP_A] ^ hist_q[BPCI_PRBS_TAP_B])
        : chk_pat_q[0]; // RULE_03
    assign match = rx.data == expect_bit;

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            chk_pat_q <= BPCI_PAT_RST;
            hist_q <= '0;
        end
        else if (load)
            chk_pat_q <= pat_q;
        else if (take)
        begin
            hist_q <= {hist_q[13:0], rx.data};
            if (match | sync_q)
                chk_pat_q <= {chk_pat_q[0], chk_pat_q[31:1]};
            else
                chk_pat_q <= {chk_pat_q[1:0], chk_pat_q[31:2]};
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            match_q <= '0;
            sync_q <= 1'b0;
        end
        else if (load)
        begin
            match_q <= '0;
            sync_q <= 1'b0;
        end
        else if (take & ~sync_q)
        begin
            if (!match)
                match_q <= '0;
            else if (match_q + 6'h01 == BPCI_SYNC_LEN)
                sync_q <= 1'b1; // RULE_23
            else
                match_q <= match_q + 6'h01;
        end
    end

    // ============================================================
    // counters and overflow flags
    logic clr_prev_q;
    logic clr_tog;
    logic [31:0] bit_cnt_q;
    logic [23:0] err_cnt_q;
    logic count;
    logic bit_full;
    logic err_full;
    logic bit_ovf_set;
    logic err_ovf_set;
    assign clr_tog = counter_clear_control_i ^ clr_prev_q;
    assign count = take & sync_q;
    assign bit_full = bit_cnt_q == BPCI_BIT_MAX;
    assign err_full = err_cnt_q == BPCI_ERR_MAX;
    assign bit_ovf_set = count & ~clr_tog
        & (bit_cnt_q == BPCI_BIT_MAX - 32'h1); // RULE_08
    assign err_ovf_set = count & ~match & ~clr_tog
        & (err_cnt_q == BPCI_ERR_MAX - 24'h1); // RULE_10

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            clr_prev_q <= 1'b0;
        else
            clr_prev_q <= counter_clear_control_i;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            bit_cnt_q <= '0;
            err_cnt_q <= '0;
        end
        else if (clr_tog)
        begin
            bit_cnt_q <= '0; // RULE_11
            err_cnt_q <= '0;
        end
        else if (count) // RULE_25
        begin
            if (!bit_full)
                bit_cnt_q <= bit_cnt_q + 32'h1; // RULE_07 RULE_08
            if (!match && !err_full)
                err_cnt_q <= err_cnt_q + 24'h1; // RULE_09 RULE_10
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            bit_counter_overflow_flag_o <= 1'b0;
            error_counter_overflow_flag_o <= 1'b0;
            pattern_sync_flag_o <= 1'b0;
        end
        else
        begin
            // set wins over a read in the same cycle
            bit_counter_overflow_flag_o <= bit_ovf_set
                | (bit_counter_overflow_flag_o & ~overflow_flags_read_i); // RULE_24
            error_counter_overflow_flag_o <= err_ovf_set
                | (error_counter_overflow_flag_o & ~overflow_flags_read_i);
            pattern_sync_flag_o <= sync_q;
        end
    end

    // ============================================================
    // read port
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rdata_q <= BPCI_BYTE_RST;
        else if (host_bus_i.rd)
        begin
            if (host_bus_i.addr == BPCI_PAT_B0_OFF)
                rdata_q <= pat_q[7:0];
            else if (host_bus_i.addr == BPCI_PAT_B1_OFF)
                rdata_q <= pat_q[15:8];
            else if (host_bus_i.addr == BPCI_PAT_B2_OFF)
                rdata_q <= pat_q[23:16];
            else if (host_bus_i.addr == BPCI_PAT_B3_OFF)
                rdata_q <= pat_q[31:24];
            else if (host_bus_i.addr == BPCI_RXB_B0_OFF)
                rdata_q <= bit_cnt_q[7:0]; // RULE_12
            else if (host_bus_i.addr == BPCI_RXB_B1_OFF)
                rdata_q <= bit_cnt_q[15:8];
            else if (host_bus_i.addr == BPCI_RXB_B2_OFF)
                rdata_q <= bit_cnt_q[23:16];
            else if (host_bus_i.addr == BPCI_RXB_B3_OFF)
                rdata_q <= bit_cnt_q[31:24];
            else if (host_bus_i.addr == BPCI_ERR_B0_OFF)
                rdata_q <= err_cnt_q[7:0]; // RULE_13
            else if (host_bus_i.addr == BPCI_ERR_B1_OFF)
                rdata_q <= err_cnt_q[15:8];
            else if (host_bus_i.addr == BPCI_ERR_B2_OFF)
                rdata_q <= err_cnt_q[23:16];
            else if (host_bus_i.addr == BPCI_CTRL_OFF)
                rdata_q <= ctrl_q;
            else
                rdata_q <= BPCI_BYTE_RST;
        end
    end
    assign host_rdata_o = rdata_q;

    // ============================================================
    // assertions
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_count_step;
        count && !clr_tog;
    endsequence
    sequence s_cleared;
        bit_cnt_q == 32'h0 && err_cnt_q == 24'h0;
    endsequence

    property p_bit_inc;
        s_count_step and (!bit_full) |=> bit_cnt_q == $past(bit_cnt_q) + 32'h1;
    endproperty
    a_bit_inc: assert property (p_bit_inc) else $error("bit count step"); // RULE_07

    property p_bit_sat;
        bit_full && !clr_tog |=> bit_full;
    endproperty
    a_bit_sat: assert property (p_bit_sat) else $error("bit count wrap"); // RULE_08

    property p_err_inc;
        s_count_step and (!match && !err_full)
            |=> err_cnt_q == $past(err_cnt_q) + 24'h1;
    endproperty
    a_err_inc: assert property (p_err_inc) else $error("err count step"); // RULE_09

    property p_err_sat;
        err_full && !clr_tog |=> err_full;
    endproperty
    a_err_sat: assert property (p_err_sat) else $error("err count wrap"); // RULE_10

    property p_clear;
        clr_tog |=> s_cleared;
    endproperty
    a_clear: assert property (p_clear) else $error("counters not cleared"); // RULE_11

    property p_hold_off;
        !en && !clr_tog |=> $stable(bit_cnt_q) && $stable(err_cnt_q);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("counter moved"); // RULE_25

    property p_sync;
        take && !sync_q && match && !load && match_q == 6'h1F |=> sync_q;
    endproperty
    a_sync: assert property (p_sync) else $error("sync not declared"); // RULE_23

    property p_flag_latch;
        bit_ovf_set |=> bit_counter_overflow_flag_o
            ##1 (bit_counter_overflow_flag_o || $past(overflow_flags_read_i));
    endproperty
    a_flag_latch: assert property (p_flag_latch) else $error("flag lost"); // RULE_24

    property p_fbit_hold;
        en && tx_req.req && tx_req.fbit && !ctrl_q[BPCI_TRANSMIT_FRAMING_SELECT_BIT]
            |=> !line_transmit_o.valid && !backplane_receive_serial_out_o.valid;
    endproperty
    a_fbit_hold: assert property (p_fbit_hold) else $error("fbit sourced"); // RULE_19
endmodule // bpci_top
`default_nettype wire

// [tb/bpci_framer_model.sv]
// framer datapath model: bit slot requests and internal loopback
`timescale 1ns/100ps
`default_nettype none
module bpci_framer_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic run_i,
    input wire logic frame_i,
    input wire logic flip_i,
    input wire bpci_pkg::bpci_txout_t tx_i,
    output bpci_pkg::bpci_txreq_t req_o,
    output bpci_pkg::bpci_rx_t rx_o
);
    import bpci_pkg::*;
    // ============================================================
    // slot requests, framing slots marked
    always_ff @(posedge clk_i or negedge rst_b_i)
        if (!rst_b_i)
            req_o <= '0;
        else
            req_o <= '{req: run_i, fbit: frame_i};
    // ============================================================
    // loopback, optional inversion, idle data shows inverse of last
    always_ff @(posedge clk_i or negedge rst_b_i)
        if (!rst_b_i)
            rx_o <= '0;
        else
            rx_o <= '{valid: tx_i.valid,
                      data: tx_i.valid ? tx_i.data ^ flip_i : ~rx_o.data,
                      fbit: frame_i};
endmodule // bpci_framer_model
`default_nettype wire

// [tb/bpci_top_bench.sv]
// self-checking bench for the pattern tester block
`timescale 1ns/100ps
`default_nettype none
module bpci_top_bench;
    import bpci_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    bpci_bus_t hb = '0;
    bpci_mode_t mode = BPCI_MODE_REPEAT;
    logic clr = 1'b0, run = 1'b0, frame = 1'b0, flip = 1'b0, dir = 1'b0;
    logic [7:0] rdata;
    logic sync, bov, eov;
    bpci_txreq_t lrq, brq;
    bpci_txout_t ltx, btx;
    bpci_rx_t lrx, brx;
    int miscompares = 0, check_count = 0, nbits, nflip, nbp;
    logic q[$];
    logic [31:0] v, b0, e0;
    logic [7:0] offs [13] = '{8'hDC, 8'hDD, 8'hDE, 8'hDF, 8'hE3, 8'hE4,
        8'hE5, 8'hE6, 8'hE7, 8'hE8, 8'hE9, 8'hEA, 8'hE0};
    bpci_top u_bpci_top (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .host_bus_i(hb), .host_rdata_o(rdata),
        .pattern_mode_i(mode), .alternating_count_register_i(8'h02),
        .counter_clear_control_i(clr), .overflow_flags_read_i(1'b0),
        .line_tx_req_i(lrq), .backplane_tx_req_i(brq),
        .line_transmit_o(ltx), .backplane_receive_serial_out_o(btx),
        .line_receive_i(lrx), .backplane_transmit_serial_in_i(brx),
        .pattern_sync_flag_o(sync), .bit_counter_overflow_flag_o(bov),
        .error_counter_overflow_flag_o(eov));
    bpci_framer_model u_bpci_framer_model_line (
        .clk_i(ref_clk_i), .rst_b_i(rst_b_i), .run_i(run & ~dir),
        .frame_i(frame), .flip_i(flip), .tx_i(ltx), .req_o(lrq),
        .rx_o(lrx));
    bpci_framer_model u_bpci_framer_model_bp (
        .clk_i(ref_clk_i), .rst_b_i(rst_b_i), .run_i(run & dir),
        .frame_i(frame), .flip_i(1'b0), .tx_i(btx), .req_o(brq),
        .rx_o(brx));
    initial
        forever #20 ref_clk_i = ~ref_clk_i;
    // ============================================================
    // traffic monitor
    always @(posedge ref_clk_i)
    begin
        if (lrx.valid | brx.valid)
            nbits++;
        if (ltx.valid & flip)
            nflip++;
        if (ltx.valid)
            q.push_back(ltx.data);
        if (btx.valid)
            nbp++;
    end
    // ============================================================
    // helpers
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
            miscompares++;
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        hb = {1'b1, 1'b0, a, d};
        @(posedge ref_clk_i);
        #1 hb = '0;
        cyc(1);
    endtask
    task rdn(input logic [7:0] a, input int n, output logic [31:0] r);
        r = '0;
        for (int i = 0; i < n; i++)
        begin
            hb = {1'b0, 1'b1, 8'(a + i), 8'h00};
            @(posedge ref_clk_i);
            #1 hb = '0;
            cyc(1);
            r[8*i+:8] = rdata;
        end
    endtask
    task pat(input logic [31:0] p);
        for (int i = 0; i < 4; i++)
            wr(8'(BPCI_PAT_B0_OFF + i), p[8*i+:8]);
    endtask
    task go(input int n);
        run = 1'b1;
        repeat (n) @(posedge ref_clk_i);
        #1 run = 1'b0;
        cyc(6);
    endtask
    task restart;
        clr = ~clr;
        cyc(2);
        nbits = 0;
        nflip = 0;
        nbp = 0;
        q.delete();
    endtask
    task counts(input logic [31:0] eb, input logic [31:0] ee);
        rdn(BPCI_RXB_B0_OFF, 4, v);
        chk("bit count", eb, v);
        rdn(BPCI_ERR_B0_OFF, 3, v);
        chk("error count", ee, v);
    endtask
    // ============================================================
    // scenarios
    task t_regs;
        foreach (offs[i])
        begin
            rdn(offs[i], 1, v);
            chk("reset value", 32'h0, v);
        end
        wr(BPCI_RXB_B0_OFF, 8'h55);
        counts(32'h0, 32'h0);
        wr(BPCI_CTRL_OFF, 8'hA4);
        rdn(BPCI_CTRL_OFF, 1, v);
        chk("unused control bits", 32'h0, v);
        pat(32'h1234_5678);
        rdn(BPCI_PAT_B0_OFF, 4, v);
        chk("pattern word", 32'h1234_5678, v);
        chk("flags", 32'h0, {sync, bov, eov});
        $display("register test done");
    endtask
    task t_line;
        pat(32'h5AD6_B5AD);
        wr(BPCI_CTRL_OFF, 8'h01);
        restart;
        go(80);
        for (int i = 0; i < 32; i++)
            chk("tx bit", {31'b0, 1'(32'h5AD6_B5AD >> i)}, {31'b0, q[i]});
        chk("backplane idle", 32'h0, nbp);
        chk("sync", 32'h1, {31'b0, sync});
        counts(nbits - 32, 32'h0);
        restart;
        run = 1'b1;
        cyc(40);
        flip = 1'b1;
        cyc(3);
        flip = 1'b0;
        go(30);
        chk("errors injected", 32'h1, {31'b0, nflip > 0});
        counts(nbits, nflip);
        $display("line test done");
    endtask
    task t_hold;
        rdn(BPCI_RXB_B0_OFF, 4, b0);
        rdn(BPCI_ERR_B0_OFF, 3, e0);
        wr(BPCI_CTRL_OFF, 8'h00);
        q.delete();
        go(40);
        chk("disabled tx", 32'h0, q.size());
        counts(b0, e0);
        restart;
        counts(32'h0, 32'h0);
        $display("hold test done");
    endtask
    task t_bp;
        dir = 1'b1;
        wr(BPCI_CTRL_OFF, 8'h03);
        pat(32'h5AD6_B5AD);
        restart;
        go(80);
        chk("line idle", 32'h0, q.size());
        chk("backplane tx", 32'h1, {31'b0, nbp > 0});
        chk("sync", 32'h1, {31'b0, sync});
        counts(nbits - 32, 32'h0);
        dir = 1'b0;
        $display("backplane test done");
    endtask
    task t_frame;
        frame = 1'b1;
        wr(BPCI_CTRL_OFF, 8'h01);
        pat(32'h5AD6_B5AD);
        restart;
        go(40);
        chk("framing slot tx", 32'h0, q.size());
        wr(BPCI_CTRL_OFF, 8'h09);
        go(60);
        chk("unframed tx", 32'h1, {31'b0, q.size() > 0});
        chk("framed rx sync", 32'h0, {31'b0, sync});
        counts(32'h0, 32'h0);
        wr(BPCI_CTRL_OFF, 8'h49);
        go(1100);
        chk("unframed rx sync", 32'h1, {31'b0, sync});
        frame = 1'b0;
        $display("framing test done");
    endtask
    task t_modes;
        for (int m = 0; m < 4; m++)
        begin
            mode = bpci_mode_t'(m);
            wr(BPCI_CTRL_OFF, 8'h01);
            pat((m == 1) ? 32'hFFFF_FFFF : 32'h5AD6_5AD6);
            go(60);
            wr(BPCI_CTRL_OFF, 8'h11);
            cyc(2);
            chk("sync after align", 32'h0, {31'b0, sync});
            restart;
            go(150);
            chk("mode sync", 32'h1, {31'b0, sync});
            rdn(BPCI_ERR_B0_OFF, 3, v);
            chk("mode errors", 32'h0, v);
        end
        mode = BPCI_MODE_ALT;
        pat(32'h0000_FFFF);
        restart;
        go(80);
        for (int i = 0; i < 64; i++)
            chk("alt word bit", {31'b0, i < 32}, {31'b0, q[i]});
        $display("mode test done");
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        v = '0;
        cyc(10);
        rst_b_i = 1'b1;
        cyc(1);
        t_regs;
        t_line;
        t_hold;
        t_bp;
        t_frame;
        t_modes;
        finish_test;
    end
    initial
    begin
        #800000;
        miscompares++;
        finish_test;
    end
endmodule // bpci_top_bench
`default_nettype wire
